// ===== logic/abu_params.svh
// constants of the address breakpoint unit: register offsets, bit positions, reset values, vectors
// assumes byte-wide registers at their printed addresses and a 16-bit cpu address bus
// Operation
// - pc address equal to break address with enable set requests a breakpoint
// - breakpoint forces software-interrupt opcode; vector depends on user or monitor mode
// - only the cpu program counter address is compared, no other bus traffic
// - break starts after current instruction, at once if match on last cycle
// - return-from-interrupt inside break routine ends the break state
// - enable bit 7 read/write, cleared by reset, gates address-match breaks
// - active bit set by hardware on match, cleared by reset, software clears
// - software writing one to active bit triggers a break without match
// - high and low break address byte registers, cleared on reset
// - timer counter halted while break is in progress
// - watchdog disabled in break when elevated test voltage is on reset pin
// - status bits clearable in break only when flag-clear enable permits
// - active in wait when enabled; flag records wait exit through break
// - inactive in stop, registers kept; break still exits stop and sets flag
// - flag-clear enable at bit 7 of its register, reset zero, one allows clearing
`ifndef ABU_PARAMS_SVH
`define ABU_PARAMS_SVH
`define ABU_ADDR_HIGH 16'hfe0c
`define ABU_ADDR_LOW 16'hfe0d
`define ABU_STAT_CTRL 16'hfe0e
`define ABU_FLAG_CTRL 16'hfe03
`define ABU_LP_STAT 16'hfe00
`define ABU_IRQ_STAT 16'hfe10
`define ABU_IRQ_MASK 16'hfe11
`define ABU_ENABLE_BIT 7
`define ABU_ACTIVE_BIT 6
`define ABU_FCE_BIT 7
`define ABU_LPFLAG_BIT 1
`define ABU_EV_ENTRY_BIT 0
`define ABU_EV_EXIT_BIT 1
`define ABU_RESET_BYTE 8'h00
`define ABU_VEC_USER 16'hfffc
`define ABU_VEC_MON 16'hfefc
`endif

// ===== logic/abu_pkg.sv
// types of the address breakpoint unit
// assumes abu_params.svh is on the include path
package abu_pkg;
  typedef enum logic [1:0] {
    ABU_IDLE = 2'b00,
    ABU_PEND = 2'b01,
    ABU_BRK = 2'b10
  } abu_state_e;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } abu_bus_s;
  typedef struct packed {
    logic [15:0] pc;
    logic pc_valid;
    logic last_cycle;
    logic rti_done;
    logic in_wait;
    logic in_stop;
    logic monitor_mode;
  } abu_cpu_s;
endpackage

// ===== logic/abu_top.sv
// address breakpoint unit: break address compare, break state, halt and flag-protect outputs
// assumes the cpu core reports pc, instruction boundary, rti completion and low-power state
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "abu_params.svh"

module abu_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire abu_pkg::abu_bus_s bus_i,
  output logic [7:0] rdata_o,
  input wire abu_pkg::abu_cpu_s cpu_i,
  input wire logic test_voltage_i,
  output logic breakpoint_request_o,
  output logic [15:0] break_vector_o,
  output logic break_in_progress_o,
  output logic timer_halt_o,
  output logic watchdog_disable_o,
  output logic flag_clear_allowed_o,
  output logic stop_exit_o,
  output logic irq_o
);
  import abu_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] addr_high_reg, addr_low_reg;
  logic enable_reg, active_reg, fce_reg, lpflag_reg;
  logic [1:0] irq_stat_reg, irq_mask_reg;
  abu_state_e state_reg, state_next;

  wire sel_high = bus_i.addr == `ABU_ADDR_HIGH;
  wire sel_low = bus_i.addr == `ABU_ADDR_LOW;
  wire sel_sc = bus_i.addr == `ABU_STAT_CTRL;
  wire sel_fc = bus_i.addr == `ABU_FLAG_CTRL;
  wire sel_lp = bus_i.addr == `ABU_LP_STAT;
  wire sel_is = bus_i.addr == `ABU_IRQ_STAT;
  wire sel_im = bus_i.addr == `ABU_IRQ_MASK;
  wire wr_sc = bus_i.wr && sel_sc;
  wire in_break = state_reg == ABU_BRK;

  ////////////////////////////////////////////////////////////////////////////
  // compare: pc only, never data traffic; compare is frozen in stop
  wire match = cpu_i.pc_valid && !cpu_i.in_stop && enable_reg &&
               cpu_i.pc == {addr_high_reg, addr_low_reg};
  wire sw_trigger = wr_sc && bus_i.wdata[`ABU_ACTIVE_BIT];
  wire trigger = match || sw_trigger;
  wire start_now = cpu_i.last_cycle || cpu_i.in_wait || cpu_i.in_stop;
  wire entry = (state_reg != ABU_BRK) && (state_next == ABU_BRK);
  wire exit_ev = in_break && cpu_i.rti_done;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ABU_IDLE: begin
        if (trigger) begin
          state_next = start_now ? ABU_BRK : ABU_PEND;
        end
      end
      ABU_PEND: begin
        if (start_now) begin
          state_next = ABU_BRK;
        end
      end
      ABU_BRK: begin
        if (cpu_i.rti_done) begin
          state_next = ABU_IDLE;
        end
      end
      default: state_next = ABU_IDLE;
    endcase
  end

  // active: hardware set wins over a software clear in the same cycle
  wire active_next = match ? 1'b1 :
                     wr_sc ? bus_i.wdata[`ABU_ACTIVE_BIT] : active_reg;
  wire lp_set = entry && (cpu_i.in_wait || cpu_i.in_stop);
  // a break routine must not wipe pending evidence unless software opted in first
  wire clear_ok = !in_break || fce_reg;
  wire lp_clr = bus_i.wr && sel_lp && clear_ok && !bus_i.wdata[`ABU_LPFLAG_BIT];
  wire [1:0] ev = {exit_ev, entry};
  wire [1:0] is_clr = (bus_i.wr && sel_is && clear_ok) ? bus_i.wdata[1:0] : 2'b00;
  wire [1:0] is_next = ev | (irq_stat_reg & ~is_clr);

  wire [7:0] rd_mux =
    sel_high ? addr_high_reg :
    sel_low ? addr_low_reg :
    sel_sc ? {enable_reg, active_reg, 6'h00} :
    sel_fc ? {fce_reg, 7'h00} :
    sel_lp ? {6'h00, lpflag_reg, 1'b0} :
    sel_is ? {6'h00, irq_stat_reg} :
    sel_im ? {6'h00, irq_mask_reg} : `ABU_RESET_BYTE;

  ////////////////////////////////////////////////////////////////////////////
  // register file; stop does not touch any of it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_high_reg <= `ABU_RESET_BYTE;
      addr_low_reg <= `ABU_RESET_BYTE;
      enable_reg <= 1'b0;
      active_reg <= 1'b0;
      fce_reg <= 1'b0;
      lpflag_reg <= 1'b0;
      irq_stat_reg <= 2'b00;
      irq_mask_reg <= 2'b00;
      state_reg <= ABU_IDLE;
    end else begin
      if (bus_i.wr && sel_high) begin
        addr_high_reg <= bus_i.wdata;
      end
      if (bus_i.wr && sel_low) begin
        addr_low_reg <= bus_i.wdata;
      end
      if (wr_sc) begin
        enable_reg <= bus_i.wdata[`ABU_ENABLE_BIT];
      end
      if (bus_i.wr && sel_fc) begin
        fce_reg <= bus_i.wdata[`ABU_FCE_BIT];
      end
      if (bus_i.wr && sel_im) begin
        irq_mask_reg <= bus_i.wdata[1:0];
      end
      active_reg <= active_next;
      lpflag_reg <= lp_set ? 1'b1 : (lp_clr ? 1'b0 : lpflag_reg);
      irq_stat_reg <= is_next;
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= `ABU_RESET_BYTE;
      breakpoint_request_o <= 1'b0;
      break_vector_o <= `ABU_VEC_USER;
      break_in_progress_o <= 1'b0;
      timer_halt_o <= 1'b0;
      watchdog_disable_o <= 1'b0;
      flag_clear_allowed_o <= 1'b1;
      stop_exit_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      rdata_o <= bus_i.rd ? rd_mux : `ABU_RESET_BYTE;
      breakpoint_request_o <= entry;
      break_vector_o <= cpu_i.monitor_mode ? `ABU_VEC_MON : `ABU_VEC_USER;
      break_in_progress_o <= state_next == ABU_BRK;
      timer_halt_o <= state_next == ABU_BRK;
      watchdog_disable_o <= (state_next == ABU_BRK) && test_voltage_i;
      flag_clear_allowed_o <= (state_next != ABU_BRK) || fce_reg;
      stop_exit_o <= entry && cpu_i.in_stop;
      irq_o <= |(is_next & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  match_request_a: assert property (
    match && cpu_i.last_cycle && state_reg == ABU_IDLE
    |=> breakpoint_request_o && break_in_progress_o)
    else $error("match did not request");

  req_pulse_a: assert property (
    breakpoint_request_o
    |=> !breakpoint_request_o)
    else $error("request longer than one cycle");

  vector_mode_a: assert property (
    breakpoint_request_o
    |-> break_vector_o == ($past(cpu_i.monitor_mode) ? `ABU_VEC_MON : `ABU_VEC_USER))
    else $error("wrong vector");

  data_traffic_a: assert property (
    !cpu_i.pc_valid && !sw_trigger && state_reg == ABU_IDLE
    |=> !breakpoint_request_o)
    else $error("data traffic caused a break");

  pend_wait_a: assert property (
    state_reg == ABU_PEND && !start_now
    |=> !breakpoint_request_o)
    else $error("break began mid instruction");

  pend_start_a: assert property (
    state_reg == ABU_PEND && start_now
    |=> breakpoint_request_o && break_in_progress_o)
    else $error("pending break not started");

  match_pend_a: assert property (
    trigger && !start_now && state_reg == ABU_IDLE
    |=> state_reg == ABU_PEND && !break_in_progress_o)
    else $error("break not deferred");

  rti_ends_a: assert property (
    exit_ev
    |=> !break_in_progress_o)
    else $error("rti kept break");

  brk_hold_a: assert property (
    in_break && !cpu_i.rti_done
    |=> in_break && break_in_progress_o)
    else $error("break ended without rti");

  disabled_nomatch_a: assert property (
    !enable_reg && !sw_trigger && state_reg == ABU_IDLE
    |=> !breakpoint_request_o)
    else $error("break while disabled");

  enable_write_a: assert property (
    wr_sc
    |=> enable_reg == $past(bus_i.wdata[`ABU_ENABLE_BIT]))
    else $error("enable bit not written");

  active_set_a: assert property (
    match
    |=> active_reg)
    else $error("active not set");

  active_write_a: assert property (
    wr_sc && !match
    |=> active_reg == $past(bus_i.wdata[`ABU_ACTIVE_BIT]))
    else $error("active bit not written");

  sw_break_a: assert property (
    sw_trigger && state_reg == ABU_IDLE && start_now
    |=> breakpoint_request_o)
    else $error("software break lost");

  sw_active_a: assert property (
    sw_trigger
    |=> active_reg)
    else $error("software break left active clear");

  addr_hold_a: assert property (
    !(bus_i.wr && sel_high)
    |=> $stable(addr_high_reg))
    else $error("address high changed");

  addr_low_hold_a: assert property (
    !(bus_i.wr && sel_low)
    |=> $stable(addr_low_reg))
    else $error("address low changed");

  addr_load_a: assert property (
    bus_i.wr && sel_high
    |=> addr_high_reg == $past(bus_i.wdata))
    else $error("address high not loaded");

  low_load_a: assert property (
    bus_i.wr && sel_low
    |=> addr_low_reg == $past(bus_i.wdata))
    else $error("address low not loaded");

  high_read_a: assert property (
    bus_i.rd && sel_high
    |=> rdata_o == $past(addr_high_reg))
    else $error("address high read wrong");

  low_read_a: assert property (
    bus_i.rd && sel_low
    |=> rdata_o == $past(addr_low_reg))
    else $error("address low read wrong");

  timer_halt_a: assert property (
    exit_ev
    |=> !timer_halt_o)
    else $error("timer still halted after rti");

  halt_entry_a: assert property (
    breakpoint_request_o
    |-> timer_halt_o)
    else $error("timer ran");

  wdog_off_a: assert property (
    watchdog_disable_o
    |-> break_in_progress_o)
    else $error("watchdog off");

  wdog_on_a: assert property (
    in_break && !cpu_i.rti_done && test_voltage_i
    |=> watchdog_disable_o)
    else $error("watchdog left running in break");

  wdog_novolt_a: assert property (
    !test_voltage_i
    |=> !watchdog_disable_o)
    else $error("watchdog off without test voltage");

  flag_guard_a: assert property (
    break_in_progress_o && !$past(fce_reg)
    |-> !flag_clear_allowed_o)
    else $error("flags clearable in break");

  clear_idle_a: assert property (
    state_reg == ABU_IDLE && !trigger
    |=> flag_clear_allowed_o)
    else $error("flags locked outside break");

  // own status bits may only gain bits while locked
  stat_protect_a: assert property (
    in_break && !fce_reg
    |=> (irq_stat_reg & $past(irq_stat_reg)) == $past(irq_stat_reg))
    else $error("status cleared in break");

  lp_protect_a: assert property (
    in_break && !fce_reg && lpflag_reg
    |=> lpflag_reg)
    else $error("lowpower flag cleared in break");

  wait_flag_a: assert property (
    entry && cpu_i.in_wait
    |=> lpflag_reg)
    else $error("wait exit not recorded");

  stop_quiet_a: assert property (
    cpu_i.in_stop && !sw_trigger && state_reg == ABU_IDLE
    |=> !breakpoint_request_o)
    else $error("compare active in stop");

  stop_exit_a: assert property (
    entry && cpu_i.in_stop
    |=> stop_exit_o && lpflag_reg)
    else $error("stop not exited");

  stop_flag_a: assert property (
    stop_exit_o
    |-> lpflag_reg)
    else $error("stop flag missing");

  fce_write_a: assert property (
    bus_i.wr && sel_fc
    |=> fce_reg == $past(bus_i.wdata[`ABU_FCE_BIT]))
    else $error("flag clear enable not written");

  fce_allow_a: assert property (
    fce_reg
    |=> flag_clear_allowed_o)
    else $error("flag clear enable ignored");

  entry_rise_a: assert property (
    $rose(break_in_progress_o)
    |-> breakpoint_request_o)
    else $error("break began without request");

  match_cov: cover property (match ##1 breakpoint_request_o);
  sw_cov: cover property (sw_trigger ##[1:20] break_in_progress_o);
  stop_cov: cover property (stop_exit_o);
  rti_cov: cover property (exit_ev);
  pend_cov: cover property (state_reg == ABU_PEND ##1 breakpoint_request_o);
endmodule

`default_nettype wire

// ===== verification/abu_cpu_model.sv
// cpu core stand-in: passes bus activity on, answers a break with an rti after a delay
// assumes the bench drives pc, fetch qualifiers and low-power state
`timescale 1ns/1ps
`default_nettype none
module abu_cpu_model #(parameter int RTI_DELAY = 40) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire abu_pkg::abu_cpu_s cmd_i,
  input wire logic breakpoint_request_i,
  output abu_pkg::abu_cpu_s cpu_o
);
  import abu_pkg::*;
  logic busy_reg;
  logic rti_reg;
  logic [7:0] cnt_reg;
  ////////////////////////////////////////////////////////////
  // a request means swi was loaded; the routine runs a fixed time, ends in rti
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_reg <= 1'b0;
      rti_reg <= 1'b0;
      cnt_reg <= 8'h00;
    end else begin
      rti_reg <= busy_reg && cnt_reg == 8'h00;
      if (breakpoint_request_i) begin
        busy_reg <= 1'b1;
        cnt_reg <= 8'(RTI_DELAY);
      end else if (busy_reg) begin
        busy_reg <= cnt_reg != 8'h00;
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
  // data traffic shares the pc lines; only pc_valid marks a fetch
  always_comb begin
    cpu_o = cmd_i;
    cpu_o.rti_done = rti_reg;
  end
endmodule
`default_nettype wire

// ===== verification/test_abu_top.sv
// bench of the address breakpoint unit: register tasks, break scenarios, verdict
// assumes design files and cpu model compiled first
`timescale 1ns/1ps
`default_nettype none
`include "abu_params.svh"
module test_abu_top;
  import abu_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  abu_bus_s bus = '0;
  logic [17:0] fet = '0;
  logic [2:0] mode = '0;
  logic tv = 1'b1;
  abu_cpu_s cpu;
  logic [7:0] rdata;
  logic breakpoint_request, busy, halt, wdd, fco, sx, irq;
  logic [15:0] vec;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  always #25 clk_i = ~clk_i;
  abu_cpu_model #(.RTI_DELAY(40)) u_cpu (.clk_i(clk_i), .rst_i(rst_i), .cmd_i({fet, 1'b0, mode}),
    .breakpoint_request_i(breakpoint_request), .cpu_o(cpu));
  abu_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata), .cpu_i(cpu),
    .test_voltage_i(tv), .breakpoint_request_o(breakpoint_request), .break_vector_o(vec), .break_in_progress_o(busy),
    .timer_halt_o(halt), .watchdog_disable_o(wdd), .flag_clear_allowed_o(fco), .stop_exit_o(sx), .irq_o(irq));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk_i);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_i);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk_i);
    bus.rd <= 1'b0;
    @(negedge clk_i);
    chk("rdata", rdata, e);
  endtask
  // one fetch-cycle of bus activity, then idle lines
  task automatic fetch(input logic [15:0] pc, input logic v, input logic last);
    @(posedge clk_i);
    fet <= {pc, v, last};
    @(posedge clk_i);
    fet <= {pc, 2'b00};
  endtask
  task automatic probe(input logic b);
    @(negedge clk_i);
    chk("request", breakpoint_request, b);
    chk("in_progress", busy, b);
  endtask
  task automatic setm(input logic [2:0] m, input logic t);
    @(posedge clk_i);
    mode <= m;
    tv <= t;
  endtask
  task automatic wait_end;
    for (int i = 0; i < 80 && busy !== 1'b0; i++) @(negedge clk_i);
    chk("in_progress", busy, 1'b0);
    chk("timer_halt", halt, 1'b0);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // far above the few hundred cycles the sequence needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`ABU_STAT_CTRL, 8'h00);
    rd(`ABU_ADDR_HIGH, 8'h00);
    rd(`ABU_FLAG_CTRL, 8'h00);
    chk("vector", vec, `ABU_VEC_USER);
    wr(`ABU_ADDR_HIGH, 8'h12);
    wr(`ABU_ADDR_LOW, 8'h34);
    rd(`ABU_ADDR_LOW, 8'h34);
    rd(16'hfe0f, 8'h00);
    wr(`ABU_IRQ_MASK, 8'h01);
    fetch(16'h1234, 1'b1, 1'b1);
    probe(1'b0);
    wr(`ABU_STAT_CTRL, 8'h80);
    fetch(16'h1234, 1'b0, 1'b1);
    probe(1'b0);
    fetch(16'h1234, 1'b1, 1'b0);
    probe(1'b0);
    fetch(16'h2000, 1'b0, 1'b1);
    probe(1'b1);
    @(negedge clk_i);
    chk("request", breakpoint_request, 1'b0);
    chk("timer_halt", halt, 1'b1);
    chk("watchdog", wdd, 1'b1);
    chk("flag_clear", fco, 1'b0);
    rd(`ABU_STAT_CTRL, 8'hc0);
    chk("irq", irq, 1'b1);
    wr(`ABU_IRQ_STAT, 8'h01);
    rd(`ABU_IRQ_STAT, 8'h01);
    wr(`ABU_FLAG_CTRL, 8'h80);
    repeat (2) @(negedge clk_i);
    chk("flag_clear", fco, 1'b1);
    wr(`ABU_STAT_CTRL, 8'h80);
    wait_end();
    setm(3'b001, 1'b0);
    wr(`ABU_STAT_CTRL, 8'hc0);
    fetch(16'h0000, 1'b0, 1'b1);
    probe(1'b1);
    chk("vector", vec, `ABU_VEC_MON);
    chk("watchdog", wdd, 1'b0);
    wait_end();
    setm(3'b100, 1'b0);
    fetch(16'h1234, 1'b1, 1'b0);
    probe(1'b1);
    wait_end();
    rd(`ABU_LP_STAT, 8'h02);
    wr(`ABU_LP_STAT, 8'h00);
    setm(3'b010, 1'b0);
    fetch(16'h1234, 1'b1, 1'b1);
    probe(1'b0);
    wr(`ABU_STAT_CTRL, 8'hc0);
    @(negedge clk_i);
    chk("stop_exit", sx, 1'b1);
    wait_end();
    rd(`ABU_ADDR_HIGH, 8'h12);
    rd(`ABU_LP_STAT, 8'h02);
    rd(`ABU_IRQ_STAT, 8'h03);
    wr(`ABU_IRQ_MASK, 8'h00);
    repeat (2) @(negedge clk_i);
    chk("irq", irq, 1'b0);
    wr(`ABU_IRQ_STAT, 8'h03);
    rd(`ABU_IRQ_STAT, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
